// ==== verilog/interrupt_state_report_params.svh ====
// Register offsets, field positions and reset values of the interrupt status block
`ifndef STATE_REPORT_PARAMS_SVH
`define STATE_REPORT_PARAMS_SVH
`define OFS_STATE_REPORT 4'h0
`define OFS_RELOAD_VALUE 4'h4
`define OFS_MODE_CTRL 4'h8
`define OFS_TIMER_VALUE 4'hC
`define VECTOR_LSB 0
`define VECTOR_MSB 5
`define LEVEL_LSB 8
`define LEVEL_MSB 10
`define RELOAD_RESET 32'h00000000
`define MODE_RESET 1'b0
`define MAX_LEVEL 3'h7
`endif

// ==== verilog/interrupt_state_report_pkg.sv ====
// Types shared by the interrupt status block
package state_report_pkg;
  typedef enum logic {
    SINGLE_VECTOR = 1'b0,
    MULTI_VECTOR = 1'b1
  } dispatch_mode_e;
  typedef logic [5:0] vector_t;
  typedef logic [2:0] level_t;
endpackage : state_report_pkg

// ==== verilog/proximity_reload_reg.sv ====
// Proximity reload value register with byte-lane writes
`timescale 1ns/1ps
`default_nettype none
`include "interrupt_state_report_params.svh"
module proximity_reload_reg #(
  parameter int Width = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [3:0] byteSel,
  input wire logic [31:0] wrData,
  output logic [Width-1:0] value
);
  // Lane logic below is fixed at four bytes
  if (Width != 32) begin : gWidthCheck
    $error("proximity_reload_reg supports only Width 32");
  end
  localparam logic [31:0] ResetValue = `RELOAD_RESET;
  logic [Width-1:0] value_q;
  assign value = value_q;
  // ------------------------------
  // Byte lanes
  // ------------------------------
  for (genvar b = 0; b < 4; b++) begin : gLane
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        value_q[8*b +: 8] <= ResetValue[8*b +: 8];
      end else if (wrEn && byteSel[b]) begin
        value_q[8*b +: 8] <= wrData[8*b +: 8];
      end
    end
  end
endmodule : proximity_reload_reg
`default_nettype wire

// ==== verilog/interrupt_state_report.sv ====
// Interrupt status report and proximity reload over classic Wishbone
//
// What this block does
// - The status word reports in bits 10 to 8 the priority level of the latest interrupt presented to the core.
// - The status word reports in bits 5 to 0 the vector number of the interrupt presented to the core.
// - Bits 31 to 11 and 7 to 6 of the status word read as zero.
// - The proximity timer loads the reload value whenever an interrupt event triggers it.
// - The reload value is a 32-bit read/write register cleared at reset.
// - Both single-vector and multi-vector dispatch modes are supported.
// - Seven priority levels, one to seven, are encoded in the reported level field.
`timescale 1ns/1ps
`default_nettype none
`include "interrupt_state_report_params.svh"
module interrupt_state_report (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic presentValid,
  input wire logic [5:0] presentVector,
  input wire logic [2:0] presentLevel,
  input wire logic proximityTrigger,
  output logic [31:0] proximityCount,
  output logic multiVector
);
  // ------------------------------
  // Bus decode
  // ------------------------------
  wire logic access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic hitState = wb_adr_i == `OFS_STATE_REPORT;
  wire logic hitReload = wb_adr_i == `OFS_RELOAD_VALUE;
  wire logic hitMode = wb_adr_i == `OFS_MODE_CTRL;
  wire logic hitTimer = wb_adr_i == `OFS_TIMER_VALUE;
  // Writes land on the edge that ends the ack cycle, one edge after ack rises, while the master still holds the request
  wire logic ackCycle = wb_cyc_i && wb_stb_i && wb_ack_o;
  wire logic wrReload = ackCycle && wb_we_i && hitReload;
  wire logic wrMode = ackCycle && wb_we_i && hitMode && wb_sel_i[0];
  // Level zero means disabled, so such a request never reaches the core
  wire logic newRequest = presentValid && (presentLevel != 3'h0);

  logic [5:0] vector_q;
  logic [2:0] level_q;
  logic mode_q;
  logic [31:0] count_q;
  logic [31:0] reloadValue;
  logic [31:0] rdData_d;
  logic [31:0] dat_q;
  logic ack_q;

  proximity_reload_reg #(
    .Width(32)
  ) uReload (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(wrReload),
    .byteSel(wb_sel_i),
    .wrData(wb_dat_i),
    .value(reloadValue)
  );

  // Reserved bits stay zero by construction
  wire logic [31:0] stateWord = {21'h000000, level_q, 2'h0, vector_q};
  assign rdData_d = hitState ? stateWord :
                    hitReload ? reloadValue :
                    hitMode ? {31'h00000000, mode_q} :
                    hitTimer ? count_q : 32'h00000000;

  // ------------------------------
  // Status capture
  // ------------------------------
  // Fields only mean something in single-vector mode; captured regardless
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_q <= 6'h00;
      level_q <= 3'h0;
    end else if (newRequest) begin
      vector_q <= presentVector;
      level_q <= presentLevel;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `MODE_RESET;
    end else if (wrMode) begin
      mode_q <= wb_dat_i[0];
    end
  end
  assign multiVector = mode_q == state_report_pkg::MULTI_VECTOR;

  // ------------------------------
  // Proximity timer load
  // ------------------------------
  // Down-count only so the load is observable; a trigger always wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 32'h00000000;
    end else if (proximityTrigger) begin
      count_q <= reloadValue;
    end else if (count_q != 32'h00000000) begin
      count_q <= count_q - 32'h00000001;
    end
  end
  assign proximityCount = count_q;

  // ------------------------------
  // Bus answer
  // ------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= access;
      dat_q <= access ? rdData_d : 32'h00000000;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ------------------------------
  // Checks: status capture
  // ------------------------------
  // Bus writes to the status word are ignored, so only accepted requests move it
  level_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    newRequest |=> level_q == $past(presentLevel))
    else $error("level not captured");
  vector_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    newRequest |=> vector_q == $past(presentVector))
    else $error("vector not captured");
  level_nonzero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (presentValid && presentLevel == 3'h0) |=> $stable(level_q))
    else $error("level zero request captured");
  level_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    newRequest |=> level_q != 3'h0)
    else $error("disabled level reported");
  status_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !newRequest |=> ($stable(vector_q) && $stable(level_q)))
    else $error("status changed without request");
  status_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wb_ack_o && $past(hitState)) |->
      (wb_dat_o[`LEVEL_MSB:`LEVEL_LSB] == $past(level_q) && wb_dat_o[`VECTOR_MSB:`VECTOR_LSB] == $past(vector_q)))
    else $error("status fields not read back");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wb_ack_o && $past(hitState)) |-> (wb_dat_o[31:11] == 21'h0 && wb_dat_o[7:6] == 2'h0))
    else $error("reserved status bits nonzero");
  status_reset_a: assert property (@(posedge clk)
    (!rst_n ##1 !rst_n) |-> (vector_q == 6'h00 && level_q == 3'h0))
    else $error("status not cleared by reset");

  // ------------------------------
  // Checks: reload, mode and timer
  // ------------------------------
  // Count checks skip the load cycle; a trigger always wins
  timer_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    proximityTrigger |=> count_q == $past(reloadValue))
    else $error("timer not reloaded");
  count_down_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!proximityTrigger && count_q != 32'h00000000) |=> count_q == $past(count_q) - 32'h00000001)
    else $error("timer not counting down");
  count_rest_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!proximityTrigger && count_q == 32'h00000000) |=> count_q == 32'h00000000)
    else $error("timer left zero untriggered");
  timer_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wb_ack_o && $past(hitTimer)) |-> wb_dat_o == $past(count_q))
    else $error("timer readback wrong");
  reload_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wrReload && wb_sel_i == 4'hF) |=> reloadValue == $past(wb_dat_i))
    else $error("reload value not written");
  reload_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wrReload |=> $stable(reloadValue))
    else $error("reload value changed without write");
  reload_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wb_ack_o && $past(hitReload)) |-> wb_dat_o == $past(reloadValue))
    else $error("reload readback wrong");
  reload_reset_a: assert property (@(posedge clk)
    (!rst_n ##1 !rst_n) |-> reloadValue == `RELOAD_RESET)
    else $error("reload not cleared by reset");
  mode_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrMode |=> multiVector == $past(wb_dat_i[0]))
    else $error("mode not written");
  mode_refused_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ackCycle && wb_we_i && hitMode && !wb_sel_i[0]) |=> $stable(mode_q))
    else $error("mode written without lane");
  mode_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wb_ack_o && $past(hitMode)) |-> wb_dat_o == {31'h00000000, $past(mode_q)})
    else $error("mode readback wrong");

  // ------------------------------
  // Checks: bus answer and reset
  // ------------------------------
  // Reset checks wait for a second low edge; the first may still see power-up unknowns
  ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    access |=> wb_ack_o)
    else $error("request not answered");
  ack_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    wb_ack_o |-> $past(access))
    else $error("ack without request");
  ack_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!wb_cyc_i || !wb_stb_i) |=> !wb_ack_o)
    else $error("ack on idle bus");
  idle_data_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wb_ack_o && $past(!(hitState || hitReload || hitMode || hitTimer))) |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read nonzero");
  reset_outputs_a: assert property (@(posedge clk)
    (!rst_n ##1 !rst_n) |->
      (!wb_ack_o && wb_dat_o == 32'h00000000 && proximityCount == 32'h00000000 && !multiVector))
    else $error("outputs not cleared by reset");
endmodule : interrupt_state_report
`default_nettype wire

// ==== verif/core_model.sv ====
// Core-side model presenting interrupts and proximity trigger events
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic clk,
  output logic presentValid,
  output logic [5:0] presentVector,
  output logic [2:0] presentLevel,
  output logic proximityTrigger
);
  initial begin
    presentValid = 1'b0;
    presentVector = 6'h2A;
    presentLevel = 3'h0;
    proximityTrigger = 1'b0;
  end
  // Released lines show the inverse so stale values never pass
  task automatic present(input logic [5:0] v, input logic [2:0] l);
    presentValid <= 1'b1;
    presentVector <= v;
    presentLevel <= l;
    @(posedge clk);
    presentValid <= 1'b0;
    presentVector <= ~v;
    presentLevel <= ~l;
  endtask : present
  task automatic fire;
    proximityTrigger <= 1'b1;
    @(posedge clk);
    proximityTrigger <= 1'b0;
  endtask : fire
endmodule : core_model
`default_nettype wire

// ==== verif/tb_interrupt_state_report.sv ====
// Testbench for the interrupt status and proximity reload block
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_state_report;
  logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, we = 1'b0, ack, pv, pt, mv;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, cnt, q;
  logic [5:0] pvec;
  logic [2:0] plvl;
  int n_fail = 0, check_count = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  core_model i_core_model (.clk(clk), .presentValid(pv), .presentVector(pvec), .presentLevel(plvl),
    .proximityTrigger(pt));
  interrupt_state_report i_interrupt_state_report (.clk(clk), .rst_n(rst_n), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .presentValid(pv), .presentVector(pvec), .presentLevel(plvl), .proximityTrigger(pt),
    .proximityCount(cnt), .multiVector(mv));
  // Bounded wait so a dead slave cannot hang the run
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    int t;
    t = 0;
    req <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++t < 20);
    if (t >= 20) begin
      n_fail++;
      $display("[ERR] ack exp 1 got %b", ack);
    end
    q = rdat;
    req <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic t_regs;
    wb(1'b0, 4'h4, 4'hF, 32'h0);
    chk("reload", 32'h0, q);
    wb(1'b0, 4'h0, 4'hF, 32'h0);
    chk("status", 32'h0, q);
    wb(1'b1, 4'h4, 4'hF, 32'hA5C35A3C);
    wb(1'b1, 4'h4, 4'h2, 32'hFFFFFFFF);
    wb(1'b0, 4'h4, 4'hF, 32'h0);
    chk("reload", 32'hA5C3FF3C, q);
    wb(1'b0, 4'h2, 4'hF, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("regs done");
  endtask : t_regs
  task automatic t_status;
    i_core_model.present(6'h3F, 3'h7);
    wb(1'b0, 4'h0, 4'hF, 32'h0);
    chk("status", 32'h0000073F, q);
    i_core_model.present(6'h15, 3'h1);
    i_core_model.present(6'h01, 3'h0);
    wb(1'b0, 4'h0, 4'hF, 32'h0);
    chk("status", 32'h00000115, q);
    wb(1'b1, 4'h0, 4'hF, 32'hFFFFFFFF);
    wb(1'b0, 4'h0, 4'hF, 32'h0);
    chk("status wr", 32'h00000115, q);
    $display("status done");
  endtask : t_status
  task automatic t_timer;
    wb(1'b1, 4'h4, 4'hF, 32'h00000009);
    i_core_model.fire();
    @(posedge clk);
    chk("count", 32'h9, cnt);
    @(posedge clk);
    chk("count", 32'h8, cnt);
    wb(1'b1, 4'h4, 4'hF, 32'h00000020);
    i_core_model.fire();
    wb(1'b0, 4'hC, 4'hF, 32'h0);
    chk("timer rd", 32'h20, q);
    wb(1'b1, 4'h8, 4'h1, 32'h1);
    chk("mode", 32'h1, {31'h0, mv});
    wb(1'b0, 4'h8, 4'hF, 32'h0);
    chk("mode rd", 32'h1, q);
    $display("timer done");
  endtask : t_timer
  task automatic t_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("count rst", 32'h0, cnt);
    chk("mode rst", 32'h0, {31'h0, mv});
    rst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, 4'h4, 4'hF, 32'h0);
    chk("reload rst", 32'h0, q);
    wb(1'b0, 4'h0, 4'hF, 32'h0);
    chk("status rst", 32'h0, q);
    $display("reset done");
  endtask : t_reset
  task automatic close_out;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_status();
    t_timer();
    t_reset();
    close_out();
  end
endmodule : tb_interrupt_state_report
`default_nettype wire
